// ---- rtl/self_poll_timeout_timers.sv ----
// self-polling timeout timers, observation window and peak clamp with Avalon-MM slave
//
// Overview of operation
// RULE1 - the 3-bit observation prescaler code selects factor 4 << code, so 4 up to 512.
// RULE2 - a nonzero 5-bit observation count N gives a window of N x factor x 64 clocks.
// RULE3 - an observation count of zero is treated as 32.
// RULE4 - the peak detector value is clamped at the 8-bit saturation threshold.
// RULE5 - the sync search limit is given in sixteenths of a bit, 0 none, 0xFF 15 15/16 bits.
// RULE6 - without symbol sync within N x 64 x 512 clocks the run cycle ends; N zero disables.
// RULE7 - with sync but no start identifier within N x 64 x 512 clocks the cycle ends.
// RULE8 - with start id but no message end within N x 64 x 512 x 2 clocks the cycle ends.
// RULE9 - all three timeout timers restart at each new run cycle.
// RULE10 - the sync timer resets to 0xFF while the start id and message end timers reset to 0.
// RULE11 - only the timer of the current phase runs, and all stop once the message is complete.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module self_poll_timeout_timers
	import sp_timer_pkg::*;
#(
	parameter int TIMEOUT_UNIT = TIMEOUT_UNIT_CYCLES,
	parameter int OBS_UNIT = OBS_UNIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire rx_events_t events,
	input wire logic obs_start,
	input wire logic [7:0] peak_raw,
	output rx_status_t status
);
	////////////////////////////////////////////////////////////////////////////////
	// register file
	logic [7:0] peak_saturation_threshold, next_peak_saturation_threshold;
	logic [7:0] level_observation_time, next_level_observation_time;
	logic [7:0] sync_search_limit, next_sync_search_limit;
	logic [7:0] sync_timeout_count, next_sync_timeout_count;
	logic [7:0] start_id_timeout_count, next_start_id_timeout_count;
	logic [7:0] message_end_timeout_count, next_message_end_timeout_count;
	logic ack, next_ack;
	logic [31:0] next_readdata;
	phase_t phase, next_phase;

	// one wait state: the ack flop releases waitrequest after the first edge that sees a request
	assign waitrequest = (read | write) & ~ack;

	function automatic logic [31:0] zext(input logic [7:0] v);
		zext = {24'h0000_00, v};
	endfunction : zext

	// write decode and read mux; only byte lane 0 carries data
	always_comb begin
		next_peak_saturation_threshold = peak_saturation_threshold;
		next_level_observation_time = level_observation_time;
		next_sync_search_limit = sync_search_limit;
		next_sync_timeout_count = sync_timeout_count;
		next_start_id_timeout_count = start_id_timeout_count;
		next_message_end_timeout_count = message_end_timeout_count;
		next_ack = (read | write) & ~ack;
		next_readdata = readdata;
		if (write && !ack && byteenable[0]) begin
			unique case (address)
				OFS_PEAK_SAT: next_peak_saturation_threshold = writedata[7:0];
				OFS_LEVEL_OBS: next_level_observation_time = writedata[7:0];
				OFS_SYNC_SEARCH: next_sync_search_limit = writedata[7:0];
				OFS_SYNC_TO: next_sync_timeout_count = writedata[7:0];
				OFS_START_ID_TO: next_start_id_timeout_count = writedata[7:0];
				OFS_MSG_END_TO: next_message_end_timeout_count = writedata[7:0];
				default: ; // unmapped or read-only: write ignored
			endcase
		end
		if (read && !ack) begin
			unique case (address)
				OFS_PEAK_SAT: next_readdata = zext(peak_saturation_threshold);
				OFS_LEVEL_OBS: next_readdata = zext(level_observation_time);
				OFS_SYNC_SEARCH: next_readdata = zext(sync_search_limit);
				OFS_SYNC_TO: next_readdata = zext(sync_timeout_count);
				OFS_START_ID_TO: next_readdata = zext(start_id_timeout_count);
				OFS_MSG_END_TO: next_readdata = zext(message_end_timeout_count);
				OFS_PHASE: next_readdata = {27'h000_0000, status.timeout, phase};
				default: next_readdata = 32'h0000_0000;
			endcase
		end
	end

	// register file flops with documented reset values
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			peak_saturation_threshold <= RST_PEAK_SAT;
			level_observation_time <= RST_LEVEL_OBS;
			sync_search_limit <= RST_SYNC_SEARCH;
			sync_timeout_count <= RST_SYNC_TO; // RULE10
			start_id_timeout_count <= RST_START_ID_TO; // RULE10
			message_end_timeout_count <= RST_MSG_END_TO; // RULE10
			ack <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			peak_saturation_threshold <= next_peak_saturation_threshold;
			level_observation_time <= next_level_observation_time;
			sync_search_limit <= next_sync_search_limit;
			sync_timeout_count <= next_sync_timeout_count;
			start_id_timeout_count <= next_start_id_timeout_count;
			message_end_timeout_count <= next_message_end_timeout_count;
			ack <= next_ack;
			readdata <= next_readdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// observation window
	// 21 bits: the longest window, 32 x 512 x 64 clocks, is exactly 2^20 and needs the top bit
	logic [20:0] obs_left, next_obs_left;
	logic obs_done, next_obs_done;
	logic [5:0] obs_n;
	logic [20:0] obs_len;

	// zero count means 32 units, so the field never asks for an empty window
	assign obs_n = (level_observation_time[OBS_COUNT_MSB:0] == 5'h00) ? OBS_ZERO_AS // RULE3
		: {1'b0, level_observation_time[OBS_COUNT_MSB:0]}; // RULE2
	// factor 4 << code, times 64 clocks per unit
	assign obs_len = 21'((obs_n * OBS_UNIT)
		<< (level_observation_time[PRESCALE_MSB:PRESCALE_LSB] + PRESCALE_BASE_LOG2)); // RULE1 RULE2

	// countdown; done pulses one cycle when the window has lasted obs_len clocks
	always_comb begin
		next_obs_left = obs_left;
		next_obs_done = 1'b0;
		// full length is loaded, as for the timeout timers, so done lands obs_len edges after start
		if (obs_start) begin
			next_obs_left = obs_len; // RULE2
		end else if (obs_left == 21'd1) begin
			next_obs_left = 21'd0;
			next_obs_done = 1'b1;
		end else if (obs_left != 21'd0) begin
			next_obs_left = obs_left - 21'd1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			obs_left <= 21'd0;
			obs_done <= 1'b0;
		end else begin
			obs_left <= next_obs_left;
			obs_done <= next_obs_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// phase tracking and timeout timer
	logic [23:0] to_left, next_to_left;
	logic to_pulse, next_to_pulse;
	logic [7:0] peak_clamped, next_peak_clamped;

	function automatic logic [23:0] span(input logic [7:0] n, input int mult);
		span = 24'(n * TIMEOUT_UNIT * mult);
	endfunction : span

	// a timer value of zero disables that phase's timeout, so the phase waits for its event; a new cycle always reloads
	always_comb begin
		next_phase = phase;
		next_to_left = to_left;
		next_to_pulse = 1'b0;
		if (events.new_cycle) begin
			next_phase = PH_SYNC; // RULE9
			next_to_left = span(sync_timeout_count, 1); // RULE9 RULE6
		end else begin
			unique case (phase)
				PH_IDLE: ;
				PH_SYNC: begin
					if (events.symbol_sync) begin
						next_phase = PH_START_ID;
						next_to_left = span(start_id_timeout_count, 1); // RULE7 RULE11
					end else if (to_left == 24'd1) begin
						next_phase = PH_IDLE; // RULE6
						next_to_pulse = 1'b1;
						next_to_left = 24'd0;
					end else if (to_left != 24'd0) begin
						next_to_left = to_left - 24'd1;
					end
				end
				PH_START_ID: begin
					if (events.start_id_found) begin
						next_phase = PH_MSG_END;
						next_to_left = span(message_end_timeout_count, MSG_END_FACTOR); // RULE8
					end else if (to_left == 24'd1) begin
						next_phase = PH_IDLE; // RULE7
						next_to_pulse = 1'b1;
						next_to_left = 24'd0;
					end else if (to_left != 24'd0) begin
						next_to_left = to_left - 24'd1;
					end
				end
				PH_MSG_END: begin
					if (events.message_end_found) begin
						next_phase = PH_IDLE; // RULE11
						next_to_left = 24'd0;
					end else if (to_left == 24'd1) begin
						next_phase = PH_IDLE; // RULE8
						next_to_pulse = 1'b1;
						next_to_left = 24'd0;
					end else if (to_left != 24'd0) begin
						next_to_left = to_left - 24'd1;
					end
				end
				default: next_phase = PH_IDLE;
			endcase
		end
		// clamp is a plain min, registered so status stays a flop output
		next_peak_clamped = (peak_raw > peak_saturation_threshold)
			? peak_saturation_threshold : peak_raw; // RULE4
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			phase <= PH_IDLE;
			to_left <= 24'd0;
			to_pulse <= 1'b0;
			peak_clamped <= 8'h00;
		end else begin
			phase <= next_phase;
			to_left <= next_to_left;
			to_pulse <= next_to_pulse;
			peak_clamped <= next_peak_clamped;
		end
	end

	// search limit is passed to the sync searcher unchanged, unit T/16
	assign status.timeout = to_pulse;
	assign status.obs_window_done = obs_done;
	assign status.peak_clamped = peak_clamped;
	assign status.sync_search_limit = sync_search_limit; // RULE5

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	int unsigned sync_age;
	always_ff @(posedge sys_clk) begin
		if (!resetn || events.new_cycle || phase != PH_SYNC) sync_age <= 0;
		else sync_age <= sync_age + 1;
	end

	// edges since the last observation start; a counter instead of a long repeat keeps tools fast
	logic [20:0] obs_age;
	logic [20:0] obs_len_seen;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			obs_age <= 21'd0;
			obs_len_seen <= 21'd0;
		end else if (obs_start) begin
			obs_age <= 21'd0;
			obs_len_seen <= obs_len;
		end else if (obs_age != 21'h1F_FFFF) begin
			obs_age <= obs_age + 21'd1; // saturates, so a stale age never wraps to a match
		end
	end

	clamp_bound_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE4
		peak_clamped <= $past(peak_saturation_threshold) || $past(!resetn))
		else $error("peak above threshold");
	sync_reset_a: assert property (@(posedge sys_clk) // RULE10
		$past(!resetn) |-> sync_timeout_count == 8'hFF && start_id_timeout_count == 8'h00
		&& message_end_timeout_count == 8'h00)
		else $error("timer reset values wrong");
	new_cycle_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE9
		events.new_cycle |=> phase == PH_SYNC && to_left == span($past(sync_timeout_count), 1))
		else $error("new cycle did not restart timers");
	sync_timeout_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE6
		$rose(to_pulse) && $past(phase) == PH_SYNC |-> sync_age ==
		span(sync_timeout_count, 1))
		else $error("sync timeout at wrong time");
	disabled_timer_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE6
		phase == PH_SYNC && to_left == 24'd0 |-> !next_to_pulse)
		else $error("disabled timer fired");
	start_id_load_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE8
		phase == PH_START_ID && !events.new_cycle && events.start_id_found
		|=> to_left == span($past(message_end_timeout_count), 2)) // RULE8
		else $error("message end load wrong");
	sync_to_id_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE7
		phase == PH_SYNC && !events.new_cycle && events.symbol_sync
		|=> phase == PH_START_ID && to_left == span($past(start_id_timeout_count), 1))
		else $error("start id phase load wrong");
	msg_done_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE11
		phase == PH_MSG_END && !events.new_cycle && events.message_end_found
		|=> phase == PH_IDLE ##1 !to_pulse)
		else $error("timers not stopped after message");
	obs_len_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
		obs_done |-> obs_age == obs_len_seen)
		else $error("observation window length wrong");
	obs_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE3
		level_observation_time == 8'h00 |-> obs_len == 21'd8192) // RULE1
		else $error("zero count not treated as 32");

	cover_timeout_c: cover property (@(posedge sys_clk) disable iff (!resetn) to_pulse);
	cover_message_c: cover property (@(posedge sys_clk) disable iff (!resetn)
		phase == PH_MSG_END ##1 phase == PH_IDLE);
	cover_obs_c: cover property (@(posedge sys_clk) disable iff (!resetn) obs_done);
	cover_start_id_c: cover property (@(posedge sys_clk) disable iff (!resetn)
		phase == PH_SYNC ##1 phase == PH_START_ID);
	cover_restart_c: cover property (@(posedge sys_clk) disable iff (!resetn)
		phase == PH_SYNC && to_left != 24'd0 ##1 events.new_cycle);
endmodule : self_poll_timeout_timers

// ---- include/sp_timer_pkg.sv ----
// package: register map, field layout, timing constants and carrier types
package sp_timer_pkg;
	localparam logic [5:0] OFS_PEAK_SAT = 6'h24;
	localparam logic [5:0] OFS_LEVEL_OBS = 6'h25;
	localparam logic [5:0] OFS_SYNC_SEARCH = 6'h26;
	localparam logic [5:0] OFS_SYNC_TO = 6'h27;
	localparam logic [5:0] OFS_START_ID_TO = 6'h28;
	localparam logic [5:0] OFS_MSG_END_TO = 6'h29;
	localparam logic [5:0] OFS_PHASE = 6'h2A;
	localparam logic [7:0] RST_PEAK_SAT = 8'h10;
	localparam logic [7:0] RST_LEVEL_OBS = 8'h00;
	localparam logic [7:0] RST_SYNC_SEARCH = 8'h87;
	localparam logic [7:0] RST_SYNC_TO = 8'hFF;
	localparam logic [7:0] RST_START_ID_TO = 8'h00;
	localparam logic [7:0] RST_MSG_END_TO = 8'h00;
	localparam int PRESCALE_MSB = 7;
	localparam int PRESCALE_LSB = 5;
	localparam int OBS_COUNT_MSB = 4;
	localparam int PRESCALE_BASE_LOG2 = 2;
	localparam int OBS_UNIT_CYCLES = 64;
	localparam logic [5:0] OBS_ZERO_AS = 6'd32;
	localparam int TIMEOUT_UNIT_CYCLES = 64 * 512;
	localparam int MSG_END_FACTOR = 2;
	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_SYNC = 4'b0010,
		PH_START_ID = 4'b0100,
		PH_MSG_END = 4'b1000
	} phase_t;
	typedef struct packed {
		logic new_cycle;
		logic symbol_sync;
		logic start_id_found;
		logic message_end_found;
	} rx_events_t;
	typedef struct packed {
		logic timeout;
		logic obs_window_done;
		logic [7:0] peak_clamped;
		logic [7:0] sync_search_limit;
	} rx_status_t;
endpackage : sp_timer_pkg

// ---- tb/tb.sv ----
// testbench for the self-polling timeout timers and observation window
`timescale 1ns/1ps
module tb;
	import sp_timer_pkg::*;
	localparam int TU = 4; // short timeout unit keeps each timer run to a few cycles
	logic sys_clk = 0;
	logic resetn = 0;
	logic [5:0] address = '0;
	logic read = 0;
	logic write = 0;
	logic [31:0] writedata = '0;
	logic [3:0] byteenable = 4'h1;
	logic [31:0] readdata;
	logic waitrequest;
	rx_events_t events = '0;
	logic obs_start = 0;
	logic [7:0] peak_raw = '0;
	rx_status_t status;
	int n_mismatch = 0;
	int n_compared = 0;
	logic [7:0] rd;
	int k;

	self_poll_timeout_timers #(.TIMEOUT_UNIT(TU), .OBS_UNIT(OBS_UNIT_CYCLES))
		i_self_poll_timeout_timers (.sys_clk(sys_clk), .resetn(resetn), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .events(events),
		.obs_start(obs_start), .peak_raw(peak_raw), .status(status));

	// free-running system clock
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// verdict, compares and bus access
	task automatic final_report;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_cnt(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %0d cycles, expected %0d", $time, got, exp);
		end
	endtask : check_cnt

	// the request holds until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int i;
		@(posedge sys_clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h00_0000, d};
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (waitrequest === 1'b0) break;
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			$display("wrong value at %0t: bus request not answered", $time);
			final_report();
		end
	endtask : bus

	// pulse one event (0 new cycle .. 3 message end, 4 observation start), count to an expiry
	task automatic fire(input int which, input int lim, output int n);
		@(posedge sys_clk);
		if (which == 4) begin
			obs_start <= 1'b1;
		end else begin
			events <= 4'b1000 >> which;
		end
		@(posedge sys_clk);
		obs_start <= 1'b0;
		events <= '0;
		n = 0;
		while (n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (status.timeout === 1'b1 || status.obs_window_done === 1'b1) break;
		end
	endtask : fire

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic sc_reset_values;
		logic [5:0] ofs [6] = '{OFS_PEAK_SAT, OFS_LEVEL_OBS, OFS_SYNC_SEARCH, OFS_SYNC_TO,
			OFS_START_ID_TO, OFS_MSG_END_TO};
		logic [7:0] rv [6] = '{8'h10, 8'h00, 8'h87, 8'hFF, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ofs[i], 8'h00, rd);
			check_val(rd, rv[i]);
		end
		bus(1'b0, 6'h30, 8'h00, rd);
		check_val(rd, 8'h00);
		bus(1'b0, OFS_PHASE, 8'h00, rd);
		check_val(rd, 8'h01);
	endtask : sc_reset_values

	// clamp follows the threshold one cycle later; limit passes straight through
	task automatic sc_clamp_limit;
		bus(1'b1, OFS_PEAK_SAT, 8'h40, rd);
		// a write without byte lane 0 must leave the register alone
		byteenable <= 4'h0;
		bus(1'b1, OFS_PEAK_SAT, 8'h99, rd);
		byteenable <= 4'h1;
		bus(1'b0, OFS_PEAK_SAT, 8'h00, rd);
		check_val(rd, 8'h40);
		@(posedge sys_clk);
		peak_raw <= 8'h55;
		repeat (2) @(posedge sys_clk);
		#1;
		check_val(status.peak_clamped, 8'h40);
		@(posedge sys_clk);
		peak_raw <= 8'h20;
		repeat (2) @(posedge sys_clk);
		#1;
		check_val(status.peak_clamped, 8'h20);
		bus(1'b1, OFS_SYNC_SEARCH, 8'hFF, rd);
		check_val(status.sync_search_limit, 8'hFF);
		bus(1'b1, OFS_SYNC_SEARCH, 8'h00, rd);
		check_val(status.sync_search_limit, 8'h00);
	endtask : sc_clamp_limit

	task automatic sc_observation;
		logic [2:0] ps [4] = '{3'h0, 3'h1, 3'h7, 3'h0};
		logic [4:0] nv [4] = '{5'h01, 5'h03, 5'h01, 5'h00};
		int len;
		for (int i = 0; i < 4; i++) begin
			len = (nv[i] == 0 ? 32 : int'(nv[i])) * 64 * (4 << ps[i]);
			bus(1'b1, OFS_LEVEL_OBS, {ps[i], nv[i]}, rd);
			fire(4, len + 5, k);
			check_cnt(k, len);
		end
	endtask : sc_observation

	// phase chain with short timers; short waits stay inside the running timer
	task automatic sc_timers;
		bus(1'b1, OFS_SYNC_TO, 8'h03, rd);
		bus(1'b1, OFS_START_ID_TO, 8'h02, rd);
		bus(1'b1, OFS_MSG_END_TO, 8'h02, rd);
		fire(0, 40, k);
		check_cnt(k, 3 * TU);
		fire(0, 4, k);
		fire(1, 40, k);
		check_cnt(k, 2 * TU);
		fire(0, 4, k);
		fire(1, 4, k);
		fire(2, 40, k);
		check_cnt(k, 2 * TU * MSG_END_FACTOR);
		fire(0, 4, k);
		fire(1, 4, k);
		fire(2, 4, k);
		fire(3, 60, k);
		check_cnt(k, 60);
		bus(1'b0, OFS_PHASE, 8'h00, rd);
		check_val(rd, 8'h01);
		fire(0, 8, k);
		fire(0, 40, k);
		check_cnt(k, 3 * TU);
		bus(1'b1, OFS_SYNC_TO, 8'h00, rd);
		fire(0, 300, k);
		check_cnt(k, 300);
		bus(1'b1, OFS_START_ID_TO, 8'h00, rd);
		fire(0, 4, k);
		fire(1, 100, k);
		check_cnt(k, 100);
	endtask : sc_timers

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		sc_reset_values();
		sc_clamp_limit();
		sc_observation();
		sc_timers();
		// a second reset in mid-run must bring registers and phase back to their reset state
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		sc_reset_values();
		final_report();
	end
endmodule : tb
